/* pmpd_pkg.sv */
`default_nettype none
package pmpd_pkg;

	// ****************************************
	// Mapping layout
	// ****************************************
	localparam int PMPD_NUM_PDO = 4;
	localparam int PMPD_NUM_ENTRIES = 4;
	localparam int PMPD_MAP_WORDS = 64;
	localparam logic [5:0] PMPD_MAP_LAST = 6'h3f;
	localparam logic [5:0] PMPD_TX_BASE = 6'h20;
	localparam int PMPD_SUB_MSB = 15;
	localparam int PMPD_SUB_LSB = 8;
	localparam int PMPD_LEN_MSB = 7;
	localparam int PMPD_LEN_LSB = 0;
	localparam logic [7:0] PMPD_LEN_8 = 8'h08;
	localparam logic [7:0] PMPD_LEN_16 = 8'h10;
	localparam logic [7:0] PMPD_PARAM_IDX_HI = 8'h20;
	localparam logic [3:0] PMPD_PAYLOAD_BYTES = 4'h8;

	// ****************************************
	// Link register addresses
	// ****************************************
	localparam logic [15:0] PMPD_LA_SETPOINT = 16'h1000;
	localparam logic [15:0] PMPD_LA_CONTROL = 16'h2000;
	localparam logic [15:0] PMPD_LA_STATUS = 16'h7000;
	localparam logic [15:0] PMPD_LA_RUN_ELEM = 16'h6000;
	localparam logic [15:0] PMPD_LA_MON_BUS = 16'h7002;
	localparam logic [15:0] PMPD_LA_MON_OVOLT = 16'h7003;
	localparam logic [15:0] PMPD_LA_MON_OCUR = 16'h7004;
	localparam logic [7:0] PMPD_LA_MAP_HI = 8'haf;

	// ****************************************
	// Register port offsets and resets
	// ****************************************
	localparam logic [7:0] PMPD_RA_MAP_LAST = 8'h3f;
	localparam logic [7:0] PMPD_RA_STATION = 8'h40;
	localparam logic [7:0] PMPD_RA_SETPOINT = 8'h41;
	localparam logic [7:0] PMPD_RA_CONTROL = 8'h42;
	localparam logic [7:0] PMPD_RA_STATUS = 8'h43;
	localparam logic [7:0] PMPD_STATION_RST = 8'h01;
	localparam logic [15:0] PMPD_MAP_RST = 16'h0000;

	// ****************************************
	// Timing
	// ****************************************
	localparam int PMPD_CLK_MHZ = 100;
	localparam int PMPD_TICK_MS = 10;
	localparam int PMPD_TICK_CYCLES = PMPD_TICK_MS * PMPD_CLK_MHZ * 1000;
	localparam int PMPD_FIFO_DEPTH = 32;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		PMPD_ST_IDLE = 2'b00,
		PMPD_ST_RX = 2'b01,
		PMPD_ST_TX = 2'b10
	} pmpd_state_e;

	typedef struct packed {
		logic [7:0] station;
		logic [15:0] addr;
		logic [15:0] data;
	} pmpd_word_s;

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] data;
	} pmpd_mon_s;

	typedef struct packed {
		logic [7:0] group;
		logic [7:0] num;
		logic [15:0] data;
	} pmpd_param_s;

endpackage
`default_nettype wire

/* pmpd_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module pmpd_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
		next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign in_ready = (count_q != (AW+1)'(DEPTH));
	assign out_valid = (count_q != '0);
	assign out_data = mem_q[rd_ptr_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge clk) begin
		if (ce && push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else if (ce) begin
			if (push) begin
				wr_ptr_q <= next_ptr(wr_ptr_q);
			end
			if (pop) begin
				rd_ptr_q <= next_ptr(rd_ptr_q);
			end
			case ({push, pop})
				2'b10: count_q <= count_q + 1'b1;
				2'b01: count_q <= count_q - 1'b1;
				default: count_q <= count_q;
			endcase
		end
	end

endmodule // pmpd_fifo
`default_nettype wire

/* pmpd_top.sv */
`timescale 1ns/10ps
`default_nettype none
module pmpd_top #(
	parameter int TICK_CYCLES = pmpd_pkg::PMPD_TICK_CYCLES,
	parameter int FIFO_DEPTH = pmpd_pkg::PMPD_FIFO_DEPTH
) (
	// Clock, reset, enable
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic CE,
	// Register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [15:0] REG_RDATA,
	// Word writes from the master
	input wire logic LNK_WR_VALID,
	input wire pmpd_pkg::pmpd_word_s LNK_WR,
	output logic LNK_WR_ACK,
	output logic LNK_WR_NAK,
	// Periodic monitor words to the master
	output logic TX_VALID,
	input wire logic TX_READY,
	output pmpd_pkg::pmpd_word_s TX_WORD,
	// Monitored values
	input wire logic [15:0] MON_BUS_VOLT,
	input wire logic [15:0] MON_OUT_VOLT,
	input wire logic [15:0] MON_OUT_CUR,
	// Drive commands
	output logic [15:0] SETPOINT,
	output logic [15:0] CONTROL_WORD,
	// Process object frames
	output logic PDO_READY,
	input wire logic RPDO_VALID,
	input wire logic [1:0] RPDO_SEL,
	input wire logic [63:0] RPDO_DATA,
	input wire logic TPDO_REQ,
	input wire logic [1:0] TPDO_SEL,
	output logic TPDO_VALID,
	output logic [1:0] TPDO_NUM,
	output logic [3:0] TPDO_LEN,
	output logic [63:0] TPDO_DATA,
	// Drive parameter writes from receive objects
	output logic PARAM_WR,
	output pmpd_pkg::pmpd_param_s PARAM
);
	import pmpd_pkg::*;

	localparam int TW = $clog2(TICK_CYCLES);

	// ****************************************
	// Reset release
	// ****************************************
	logic [1:0] rst_sync_q;
	logic rst_n;

	// Free running so reset releases even while frozen
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [5:0] map_addr(input logic tx, input logic [1:0] pdo, input logic [1:0] ent,
		input logic lo);
		map_addr = {tx, pdo, ent, lo};
	endfunction

	function automatic logic [3:0] len_bytes(input logic [7:0] len);
		len_bytes = (len[7] || (len[2:0] != 3'b000)) ? 4'h0 : len[6:3];
	endfunction

	// ****************************************
	// Mapping store and register port
	// ****************************************
	logic [15:0] map_mem [PMPD_MAP_WORDS];
	logic [7:0] station_q;
	logic [15:0] setpoint_q;
	logic [15:0] control_q;
	logic [15:0] rdata_q;
	logic port_map_wr;
	logic lnk_station_ok;
	logic lnk_map_hit;
	logic lnk_map_wr;
	logic lnk_accept;
	pmpd_state_e st_q;
	pmpd_state_e st_d;

	assign port_map_wr = REG_WR && (REG_ADDR <= PMPD_RA_MAP_LAST);
	assign lnk_station_ok = (LNK_WR.station == station_q);
	assign lnk_map_hit = (LNK_WR.addr[15:8] == PMPD_LA_MAP_HI) && (LNK_WR.addr[7:6] == 2'b00);
	assign lnk_map_wr = LNK_WR_VALID && lnk_station_ok && lnk_map_hit && !port_map_wr;
	// Only writable registers take data
	assign lnk_accept = LNK_WR_VALID && lnk_station_ok &&
		((LNK_WR.addr == PMPD_LA_SETPOINT) || (LNK_WR.addr == PMPD_LA_CONTROL) || lnk_map_wr);

	// Both sources land in the same store, port first
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < PMPD_MAP_WORDS; i++) begin
				map_mem[i] <= PMPD_MAP_RST;
			end
		end else if (CE) begin
			if (port_map_wr) begin
				map_mem[REG_ADDR[5:0]] <= REG_WDATA;
			end else if (lnk_map_wr) begin
				map_mem[LNK_WR.addr[5:0]] <= LNK_WR.data;
			end
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			station_q <= PMPD_STATION_RST;
		end else if (CE && REG_WR && (REG_ADDR == PMPD_RA_STATION)) begin
			station_q <= REG_WDATA[7:0];
		end
	end

	// Setpoint and control word from the periodic writes
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			setpoint_q <= 16'h0000;
			control_q <= 16'h0000;
			LNK_WR_ACK <= 1'b0;
			LNK_WR_NAK <= 1'b0;
		end else if (CE) begin
			if (lnk_accept && (LNK_WR.addr == PMPD_LA_SETPOINT)) begin
				setpoint_q <= LNK_WR.data;
			end
			if (lnk_accept && (LNK_WR.addr == PMPD_LA_CONTROL)) begin
				control_q <= LNK_WR.data;
			end
			LNK_WR_ACK <= lnk_accept;
			LNK_WR_NAK <= LNK_WR_VALID && !lnk_accept;
		end
	end
	assign SETPOINT = setpoint_q;
	assign CONTROL_WORD = control_q;

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 16'h0000;
		end else if (CE) begin
			if (!REG_RD) begin
				rdata_q <= 16'h0000;
			end else if (REG_ADDR <= PMPD_RA_MAP_LAST) begin
				rdata_q <= map_mem[REG_ADDR[5:0]];
			end else begin
				case (REG_ADDR)
					PMPD_RA_STATION: rdata_q <= {8'h00, station_q};
					PMPD_RA_SETPOINT: rdata_q <= setpoint_q;
					PMPD_RA_CONTROL: rdata_q <= control_q;
					PMPD_RA_STATUS: rdata_q <= {13'h0000, TX_VALID, st_q};
					default: rdata_q <= 16'h0000;
				endcase
			end
		end
	end
	assign REG_RDATA = rdata_q;

	// ****************************************
	// Periodic monitor words
	// ****************************************
	logic [TW-1:0] tick_cnt_q;
	logic tick;
	logic [1:0] mon_idx_q;
	logic mon_push;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	pmpd_mon_s mon_word;
	pmpd_mon_s fifo_out;
	pmpd_word_s tx_word_q;
	logic tx_valid_q;

	assign tick = (tick_cnt_q == TW'(TICK_CYCLES - 1));

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_q <= '0;
		end else if (CE) begin
			tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
		end
	end

	always_comb begin
		case (mon_idx_q)
			2'd1: mon_word = '{addr: PMPD_LA_MON_BUS, data: MON_BUS_VOLT};
			2'd2: mon_word = '{addr: PMPD_LA_MON_OVOLT, data: MON_OUT_VOLT};
			default: mon_word = '{addr: PMPD_LA_MON_OCUR, data: MON_OUT_CUR};
		endcase
	end
	assign mon_push = (mon_idx_q != 2'd0);

	// Full queue stalls the burst; a tick during a burst is dropped
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			mon_idx_q <= 2'd0;
		end else if (CE) begin
			if (mon_idx_q == 2'd0) begin
				mon_idx_q <= tick ? 2'd1 : 2'd0;
			end else if (fifo_in_ready) begin
				mon_idx_q <= (mon_idx_q == 2'd3) ? 2'd0 : mon_idx_q + 2'd1;
			end
		end
	end

	pmpd_fifo #(
		.WIDTH($bits(pmpd_mon_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(CLK),
		.rst_n(rst_n),
		.ce(CE),
		.in_valid(mon_push),
		.in_ready(fifo_in_ready),
		.in_data(mon_word),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out)
	);

	assign fifo_out_ready = !tx_valid_q || TX_READY;

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			tx_valid_q <= 1'b0;
			tx_word_q <= '0;
		end else if (CE && fifo_out_ready) begin
			tx_valid_q <= fifo_out_valid;
			tx_word_q <= '{station: station_q, addr: fifo_out.addr, data: fifo_out.data};
		end
	end
	assign TX_VALID = tx_valid_q;
	assign TX_WORD = tx_word_q;

	// ****************************************
	// Process object walk, one entry a cycle
	// ****************************************
	logic [1:0] pdo_q;
	logic [1:0] ent_q;
	logic [3:0] off_q;
	logic [63:0] buf_q;
	logic ready_q;
	logic [15:0] ent_idx;
	logic [15:0] ent_lo;
	logic [7:0] ent_sub;
	logic [3:0] ent_bytes;
	logic ent_fits;
	logic [15:0] ent_mask;
	logic [15:0] rx_val;
	logic [15:0] tx_val;
	logic [3:0] off_nxt;
	logic [63:0] buf_nxt;
	logic is_param;
	logic tpdo_valid_q;
	logic param_wr_q;
	pmpd_param_s param_q;

	always_comb begin
		ent_idx = map_mem[map_addr(st_q == PMPD_ST_TX, pdo_q, ent_q, 1'b0)];
		ent_lo = map_mem[map_addr(st_q == PMPD_ST_TX, pdo_q, ent_q, 1'b1)];
		ent_sub = ent_lo[PMPD_SUB_MSB:PMPD_SUB_LSB];
		ent_bytes = len_bytes(ent_lo[PMPD_LEN_MSB:PMPD_LEN_LSB]);
		ent_fits = (ent_bytes != 4'h0) && ({1'b0, off_q} + {1'b0, ent_bytes} <= {1'b0, PMPD_PAYLOAD_BYTES});
		ent_mask = (ent_bytes == 4'h1) ? 16'h00ff : 16'hffff;
		rx_val = 16'(buf_q >> {off_q, 3'b000}) & ent_mask;
		// Drive parameter: 2000h+group, sub-index is number+1
		is_param = (ent_idx[15:8] == PMPD_PARAM_IDX_HI) && (ent_sub != 8'h00);
		// Standard objects by their own index alone; sub-index is not looked at
		case (ent_idx)
			PMPD_LA_SETPOINT: tx_val = setpoint_q;
			PMPD_LA_CONTROL: tx_val = control_q;
			PMPD_LA_STATUS: tx_val = {14'h0000, st_q};
			PMPD_LA_MON_BUS: tx_val = MON_BUS_VOLT;
			PMPD_LA_MON_OVOLT: tx_val = MON_OUT_VOLT;
			PMPD_LA_MON_OCUR: tx_val = MON_OUT_CUR;
			default: tx_val = 16'h0000;
		endcase
		// Entry order; empty or oversized entries add nothing
		off_nxt = ent_fits ? off_q + ent_bytes : off_q;
		buf_nxt = buf_q;
		if (ent_fits && (st_q == PMPD_ST_TX)) begin
			buf_nxt = buf_q | (64'(tx_val & ent_mask) << {off_q, 3'b000});
		end
	end

	always_comb begin
		case (st_q)
			PMPD_ST_IDLE: begin
				if (RPDO_VALID) begin
					st_d = PMPD_ST_RX;
				end else if (TPDO_REQ) begin
					st_d = PMPD_ST_TX;
				end else begin
					st_d = PMPD_ST_IDLE;
				end
			end
			PMPD_ST_RX, PMPD_ST_TX: st_d = (ent_q == 2'd3) ? PMPD_ST_IDLE : st_q;
			default: st_d = PMPD_ST_IDLE;
		endcase
	end

	// Four objects each way, receive and transmit, selected by a 2-bit number
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= PMPD_ST_IDLE;
			pdo_q <= 2'd0;
			ent_q <= 2'd0;
			off_q <= 4'h0;
			buf_q <= 64'h0;
			ready_q <= 1'b0;
		end else if (CE) begin
			st_q <= st_d;
			ready_q <= (st_d == PMPD_ST_IDLE);
			if (st_q == PMPD_ST_IDLE) begin
				pdo_q <= RPDO_VALID ? RPDO_SEL : TPDO_SEL;
				buf_q <= RPDO_VALID ? RPDO_DATA : 64'h0;
				ent_q <= 2'd0;
				off_q <= 4'h0;
			end else begin
				ent_q <= ent_q + 2'd1;
				off_q <= off_nxt;
				buf_q <= buf_nxt;
			end
		end
	end
	assign PDO_READY = ready_q;

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			tpdo_valid_q <= 1'b0;
			TPDO_NUM <= 2'd0;
			TPDO_LEN <= 4'h0;
			TPDO_DATA <= 64'h0;
			param_wr_q <= 1'b0;
			param_q <= '0;
		end else if (CE) begin
			tpdo_valid_q <= (st_q == PMPD_ST_TX) && (ent_q == 2'd3);
			if ((st_q == PMPD_ST_TX) && (ent_q == 2'd3)) begin
				TPDO_NUM <= pdo_q;
				TPDO_LEN <= off_nxt;
				TPDO_DATA <= buf_nxt;
			end
			param_wr_q <= (st_q == PMPD_ST_RX) && ent_fits && is_param;
			if ((st_q == PMPD_ST_RX) && ent_fits && is_param) begin
				param_q <= '{group: ent_idx[7:0], num: ent_sub - 8'h01, data: rx_val};
			end
		end
	end
	assign TPDO_VALID = tpdo_valid_q;
	assign PARAM_WR = param_wr_q;
	assign PARAM = param_q;

	// ****************************************
	// Checks
	// ****************************************
	a_rx_base_layout: assert property (@(posedge CLK) disable iff (!rst_n)
		(st_q == PMPD_ST_RX) |->
		(map_addr(st_q == PMPD_ST_TX, pdo_q, ent_q, 1'b0) == 6'(pdo_q * 8 + ent_q * 2)))
		else $error("receive entry read outside words 0..31");
	a_tx_base_layout: assert property (@(posedge CLK) disable iff (!rst_n)
		(st_q == PMPD_ST_TX) |->
		(map_addr(st_q == PMPD_ST_TX, pdo_q, ent_q, 1'b0) == PMPD_TX_BASE + 6'(pdo_q * 8 + ent_q * 2)))
		else $error("transmit entry read at the wrong word");
	a_walk_four_entries: assert property (@(posedge CLK) disable iff (!rst_n || !CE)
		(st_q == PMPD_ST_IDLE && st_d != PMPD_ST_IDLE) |=> (st_q != PMPD_ST_IDLE)[*4] ##1 (st_q == PMPD_ST_IDLE))
		else $error("object walk not four entries long");
	a_map_port_write: assert property (@(posedge CLK) disable iff (!rst_n || !CE)
		port_map_wr |=> (map_mem[$past(REG_ADDR[5:0])] == $past(REG_WDATA)))
		else $error("direct mapping write lost");
	a_map_link_write: assert property (@(posedge CLK) disable iff (!rst_n || !CE)
		lnk_map_wr |=> (map_mem[$past(LNK_WR.addr[5:0])] == $past(LNK_WR.data)) && LNK_WR_ACK)
		else $error("master mapping write lost");
	a_setpoint_taken: assert property (@(posedge CLK) disable iff (!rst_n || !CE)
		(LNK_WR_VALID && lnk_station_ok && LNK_WR.addr == PMPD_LA_SETPOINT)
		|=> LNK_WR_ACK && (SETPOINT == $past(LNK_WR.data)))
		else $error("setpoint write not taken");
	a_wrong_station: assert property (@(posedge CLK) disable iff (!rst_n || !CE)
		(LNK_WR_VALID && !lnk_station_ok) |=> LNK_WR_NAK && !LNK_WR_ACK && $stable(CONTROL_WORD))
		else $error("foreign station write accepted");
	a_mon_burst_start: assert property (@(posedge CLK) disable iff (!rst_n || !CE)
		(tick && mon_idx_q == 2'd0) |=> (mon_idx_q == 2'd1) && (mon_word.addr == PMPD_LA_MON_BUS))
		else $error("tick did not start monitor burst");
	a_param_encoding: assert property (@(posedge CLK) disable iff (!rst_n || !CE)
		PARAM_WR |-> (PARAM.num + 8'h01 == $past(ent_sub)) && (PARAM.group == $past(ent_idx[7:0])))
		else $error("parameter number or group mis-decoded");
	a_empty_entry_skip: assert property (@(posedge CLK) disable iff (!rst_n || !CE)
		(st_q != PMPD_ST_IDLE && ent_bytes == 4'h0) |=> (off_q == $past(off_q)))
		else $error("empty entry moved the payload offset");
	a_tpdo_len_bound: assert property (@(posedge CLK) disable iff (!rst_n)
		TPDO_VALID |-> (TPDO_LEN <= PMPD_PAYLOAD_BYTES))
		else $error("transmit payload longer than eight bytes");

endmodule // pmpd_top
`default_nettype wire

/* pmpd_master_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Master side sink of monitor words
// ****************************************
module pmpd_master_model
	import pmpd_pkg::*;
#(
	parameter logic [7:0] OWN_STATION = 8'h01
) (
	// Clock and reset; the drive's own clock, so rates agree
	input wire logic clk,
	input wire logic rst_n,
	// Pacing
	input wire logic stall,
	input wire logic slow,
	// Monitor stream
	input wire logic tx_valid,
	input wire pmpd_pkg::pmpd_word_s tx_word,
	output logic tx_ready,
	// Observations
	output int rx_cnt,
	output logic order_err,
	output logic [15:0] seen_bus,
	output logic [15:0] seen_ovolt,
	output logic [15:0] seen_ocur
);
	// Master's own link number, never a drive's
	localparam logic [7:0] HOST_STATION = 8'h3f;
	logic [15:0] next_addr_q;
	logic phase_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= 1'b0;
		end else begin
			phase_q <= ~phase_q;
		end
	end

	// Slow mode takes a word on every other cycle only
	assign tx_ready = !stall && (!slow || phase_q);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_cnt <= 0;
			order_err <= 1'b0;
			next_addr_q <= PMPD_LA_MON_BUS;
			seen_bus <= 16'h0000;
			seen_ovolt <= 16'h0000;
			seen_ocur <= 16'h0000;
		end else if (tx_valid && tx_ready) begin
			rx_cnt <= rx_cnt + 1;
			// Words out of order or of another station are taken but set order_err
			if (tx_word.addr !== next_addr_q || tx_word.station !== OWN_STATION ||
				tx_word.station === HOST_STATION) begin
				order_err <= 1'b1;
			end
			next_addr_q <= (tx_word.addr == PMPD_LA_MON_OCUR) ? PMPD_LA_MON_BUS : tx_word.addr + 16'h0001;
			case (tx_word.addr)
				PMPD_LA_MON_BUS: seen_bus <= tx_word.data;
				PMPD_LA_MON_OVOLT: seen_ovolt <= tx_word.data;
				PMPD_LA_MON_OCUR: seen_ocur <= tx_word.data;
				default: ;
			endcase
		end
	end
endmodule // pmpd_master_model
`default_nettype wire

/* pdo_mapping_process_data_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module pdo_mapping_process_data_bench;
	import pmpd_pkg::*;
	localparam int TICK = 50;
	typedef struct packed {
		logic lk;
		logic [7:0] st;
		logic [15:0] addr;
		logic [15:0] data;
		logic [1:0] resp;
		logic [7:0] rd;
		logic [15:0] exp;
	} pmpd_row_s;
	// ****************************************
	// Ordinary cases: reg or link write, then read back
	// ****************************************
	pmpd_row_s rows [13] = '{
		'{1'b0, 8'h00, 16'h0000, 16'h1234, 2'd0, 8'h00, 16'h1234},
		'{1'b0, 8'h00, 16'h0007, 16'ha5a5, 2'd0, 8'h07, 16'ha5a5},
		'{1'b0, 8'h00, 16'h003e, 16'h1111, 2'd0, 8'h3e, 16'h1111},
		'{1'b0, 8'h00, 16'h0041, 16'hffff, 2'd0, 8'h41, 16'h0000},
		'{1'b0, 8'h00, 16'h0080, 16'hffff, 2'd0, 8'h80, 16'h0000},
		'{1'b1, 8'h01, 16'h1000, 16'h1234, 2'd1, 8'h41, 16'h1234},
		'{1'b1, 8'h01, 16'h2000, 16'h0006, 2'd1, 8'h42, 16'h0006},
		'{1'b1, 8'h01, 16'h3000, 16'h5555, 2'd2, 8'h41, 16'h1234},
		'{1'b1, 8'h02, 16'h1000, 16'h9999, 2'd2, 8'h41, 16'h1234},
		'{1'b1, 8'h01, 16'haf08, 16'h20f0, 2'd1, 8'h08, 16'h20f0},
		'{1'b1, 8'h01, 16'haf09, 16'h0210, 2'd1, 8'h09, 16'h0210},
		'{1'b1, 8'h01, 16'haf0a, 16'h6060, 2'd1, 8'h0a, 16'h6060},
		'{1'b1, 8'h01, 16'haf0b, 16'h0008, 2'd1, 8'h0b, 16'h0008}
	};
	// Transmit maps: object 0 at 20, object 3 at 38 with an odd length
	logic [23:0] txmap [12] = '{24'h207002, 24'h210010, 24'h226060, 24'h230008, 24'h247000, 24'h250010, 24'h381000,
		24'h390010, 24'h3a7003, 24'h3b000c, 24'h3c7004, 24'h3d0008};
	logic CLK, RSTN, CE, REG_WR, REG_RD, LNK_WR_VALID, LNK_WR_ACK, LNK_WR_NAK, TX_VALID, TX_READY;
	logic [7:0] REG_ADDR;
	logic [15:0] REG_WDATA, REG_RDATA, MON_BUS_VOLT, MON_OUT_VOLT, MON_OUT_CUR, SETPOINT, CONTROL_WORD;
	pmpd_word_s LNK_WR, TX_WORD;
	pmpd_param_s PARAM;
	logic PDO_READY, RPDO_VALID, TPDO_REQ, TPDO_VALID, PARAM_WR, stall, slow, order_err;
	logic [1:0] RPDO_SEL, TPDO_SEL, TPDO_NUM;
	logic [3:0] TPDO_LEN;
	logic [63:0] RPDO_DATA, TPDO_DATA;
	logic [15:0] seen_bus, seen_ovolt, seen_ocur, d;
	int rx_cnt, failures, cmp_count, i, base;

	always #5 CLK = ~CLK;

	pmpd_top #(.TICK_CYCLES(TICK), .FIFO_DEPTH(PMPD_FIFO_DEPTH)) dut_u (.CLK(CLK), .RSTN(RSTN), .CE(CE),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.LNK_WR_VALID(LNK_WR_VALID), .LNK_WR(LNK_WR), .LNK_WR_ACK(LNK_WR_ACK), .LNK_WR_NAK(LNK_WR_NAK),
		.TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_WORD(TX_WORD), .MON_BUS_VOLT(MON_BUS_VOLT),
		.MON_OUT_VOLT(MON_OUT_VOLT), .MON_OUT_CUR(MON_OUT_CUR), .SETPOINT(SETPOINT), .CONTROL_WORD(CONTROL_WORD),
		.PDO_READY(PDO_READY), .RPDO_VALID(RPDO_VALID), .RPDO_SEL(RPDO_SEL), .RPDO_DATA(RPDO_DATA),
		.TPDO_REQ(TPDO_REQ), .TPDO_SEL(TPDO_SEL), .TPDO_VALID(TPDO_VALID), .TPDO_NUM(TPDO_NUM),
		.TPDO_LEN(TPDO_LEN), .TPDO_DATA(TPDO_DATA), .PARAM_WR(PARAM_WR), .PARAM(PARAM));

	pmpd_master_model model_u (.clk(CLK), .rst_n(RSTN), .stall(stall), .slow(slow), .tx_valid(TX_VALID),
		.tx_word(TX_WORD), .tx_ready(TX_READY), .rx_cnt(rx_cnt), .order_err(order_err), .seen_bus(seen_bus),
		.seen_ovolt(seen_ovolt), .seen_ocur(seen_ocur));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge CLK);
		REG_WR <= 1'b1; REG_ADDR <= a; REG_WDATA <= v;
		@(posedge CLK);
		REG_WR <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge CLK);
		REG_RD <= 1'b1; REG_ADDR <= a;
		@(posedge CLK);
		REG_RD <= 1'b0;
		#1 v = REG_RDATA;
	endtask
	task automatic lnk_wr(input pmpd_word_s w, input logic [1:0] resp);
		@(posedge CLK);
		LNK_WR_VALID <= 1'b1; LNK_WR <= w;
		@(posedge CLK);
		LNK_WR_VALID <= 1'b0;
		#1 chk("link answer", resp[0] ? 2'b10 : {1'b0, resp[1]}, {LNK_WR_ACK, LNK_WR_NAK});
	endtask
	task automatic wait_ready();
		for (i = 0; i < 20 && PDO_READY !== 1'b1; i++) @(posedge CLK) #1;
		if (i == 20) begin
			chk("object walker idle", 1, 0);
			end_sim();
		end
	endtask
	task automatic tpdo(input logic [1:0] sel);
		wait_ready();
		@(posedge CLK);
		TPDO_REQ <= 1'b1; TPDO_SEL <= sel;
		@(posedge CLK);
		TPDO_REQ <= 1'b0;
		for (i = 0; i < 12 && TPDO_VALID !== 1'b1; i++) #1 if (TPDO_VALID !== 1'b1) @(posedge CLK);
		if (i == 12) begin
			chk("transmit object built", 1, 0);
			end_sim();
		end
		chk("tpdo number", sel, TPDO_NUM);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		CLK = 0; RSTN = 0; CE = 1; REG_WR = 0; REG_RD = 0; REG_ADDR = 0; REG_WDATA = 0;
		LNK_WR_VALID = 0; LNK_WR = '0; RPDO_VALID = 0; RPDO_SEL = 0; RPDO_DATA = 0; TPDO_REQ = 0; TPDO_SEL = 0;
		MON_BUS_VOLT = 16'h0312; MON_OUT_VOLT = 16'h0190; MON_OUT_CUR = 16'h0045; stall = 0; slow = 0;
		failures = 0; cmp_count = 0;
		repeat (8) @(posedge CLK);
		RSTN <= 1'b1;
		repeat (3) @(posedge CLK);
		reg_rd(PMPD_RA_STATION, d);
		chk("station reset", PMPD_STATION_RST, d);
		@(posedge CLK);
		#1 chk("read data cleared", 16'h0000, REG_RDATA);
		reg_rd(PMPD_RA_MAP_LAST, d);
		chk("mapping reset", PMPD_MAP_RST, d);
		chk("setpoint reset", 16'h0000, SETPOINT);
		// Empty objects carry no bytes
		tpdo(2'd2);
		chk("empty tpdo length", 4'h0, TPDO_LEN);
		foreach (rows[k]) begin
			if (rows[k].lk) lnk_wr({rows[k].st, rows[k].addr, rows[k].data}, rows[k].resp);
			else reg_wr(rows[k].addr[7:0], rows[k].data);
			reg_rd(rows[k].rd, d);
			chk("read back", rows[k].exp, d);
		end
		chk("setpoint port", 16'h1234, SETPOINT);
		chk("control port", 16'h0006, CONTROL_WORD);
		foreach (txmap[k]) reg_wr(txmap[k][23:16], txmap[k][15:0]);
		tpdo(2'd0);
		chk("tpdo0 length", 4'h5, TPDO_LEN);
		chk("tpdo0 data", {24'h0, 14'h0, PMPD_ST_TX, 8'h00, MON_BUS_VOLT}, TPDO_DATA);
		tpdo(2'd3);
		chk("tpdo3 length", 4'h3, TPDO_LEN);
		chk("tpdo3 data", {40'h0, MON_OUT_CUR[7:0], 16'h1234}, TPDO_DATA);
		// Receive object 1: drive parameter then an 8-bit standard object
		wait_ready();
		@(posedge CLK);
		RPDO_VALID <= 1'b1; RPDO_SEL <= 2'd1; RPDO_DATA <= 64'h0000_0000_0055_beef;
		@(posedge CLK);
		RPDO_VALID <= 1'b0;
		base = 0;
		for (i = 0; i < 10; i++) begin
			#1 if (PARAM_WR === 1'b1) base++;
			@(posedge CLK);
		end
		chk("param writes", 1, base);
		chk("param fields", {8'hf0, 8'h01, 16'hbeef}, PARAM);
		// Monitor words, prompt then slow sink
		chk("monitor order", 1'b0, order_err);
		chk("words arrived", 1'b1, rx_cnt > 0);
		slow <= 1'b1;
		repeat (6 * TICK) @(posedge CLK);
		chk("bus volt word", MON_BUS_VOLT, seen_bus);
		chk("out volt word", MON_OUT_VOLT, seen_ovolt);
		chk("out cur word", MON_OUT_CUR, seen_ocur);
		// Fill the queue until it refuses, then drain it
		stall <= 1'b1;
		slow <= 1'b0;
		repeat (14 * TICK) @(posedge CLK);
		reg_rd(PMPD_RA_STATUS, d);
		chk("status while stalled", 16'h0004, d);
		base = rx_cnt;
		stall <= 1'b1;
		repeat (TICK) @(posedge CLK);
		chk("no words while stalled", base, rx_cnt);
		stall <= 1'b0;
		repeat (3 * PMPD_FIFO_DEPTH) @(posedge CLK);
		#1;
		chk("drained words", 1'b1, rx_cnt - base >= PMPD_FIFO_DEPTH);
		chk("order after drain", 1'b0, order_err);
		// Frozen block answers no link word and keeps its setpoint
		@(posedge CLK);
		stall <= 1'b1;
		CE <= 1'b0;
		lnk_wr('{8'h01, PMPD_LA_SETPOINT, 16'h4321}, 2'd0);
		chk("frozen setpoint", 16'h1234, SETPOINT);
		@(posedge CLK);
		CE <= 1'b1;
		stall <= 1'b0;
		end_sim();
	end
endmodule // pdo_mapping_process_data_bench
`default_nettype wire
